// >>> prfu_pkg.sv
// constants and types for the upper physical request filter
// assumes a single 40 MHz register clock and a plain strobe register port
package prfu_pkg;

  // register port geometry
  localparam int unsigned PRFU_ADDR_W = 12;
  localparam int unsigned PRFU_DATA_W = 32;

  // byte offsets of the set/clear pair
  localparam logic [11:0] PRFU_OFS_SET = 12'h110;
  localparam logic [11:0] PRFU_OFS_CLR = 12'h114;

  // byte offsets of the routing counters
  localparam logic [11:0] PRFU_OFS_CNT_PHYS = 12'h300;
  localparam logic [11:0] PRFU_OFS_CNT_ASYNC = 12'h304;
  localparam logic [11:0] PRFU_OFS_CNT_DROP = 12'h308;

  // value after power-on reset
  localparam logic [31:0] PRFU_FILTER_RST = 32'h00000000;
  localparam logic [31:0] PRFU_RD_NONE = 32'h00000000;

  // field positions
  localparam int unsigned PRFU_ALL_BUS_BIT = 31;
  localparam int unsigned PRFU_NODE_MSB = 30;
  localparam int unsigned PRFU_NODE_BITS = 31;

  // node numbering of the upper half
  localparam int unsigned PRFU_NODE_W = 6;
  localparam logic [5:0] PRFU_NODE_FIRST = 6'h20;
  localparam logic [5:0] PRFU_NODE_LAST = 6'h3E;

  // counter default width
  localparam int unsigned PRFU_CNT_W = 16;

  // routing outcome for one request
  typedef enum logic [2:0] {
    PRFU_RT_PHYS,
    PRFU_RT_ASYNC,
    PRFU_RT_DROP,
    PRFU_RT_OTHER
  } prfu_route_t;

endpackage

// >>> prfu_decide.sv
// per-request routing decision for upper node ids
// assumes request inputs come from logic on ref_clk, one cycle pulses
`timescale 1ns/1ps

module prfu_decide (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // request from the receive path
  input wire logic pkt_valid,
  input wire logic [prfu_pkg::PRFU_NODE_W-1:0] pkt_src_node,
  input wire logic pkt_src_local,
  input wire logic pkt_async_accept,
  // filter state
  input wire logic [prfu_pkg::PRFU_NODE_BITS-1:0] per_node_physical_enable,
  input wire logic accept_all_remote_buses,
  // decision
  output logic dec_valid_ff,
  output prfu_pkg::prfu_route_t dec_route_ff,
  output logic [prfu_pkg::PRFU_NODE_W-1:0] dec_node_ff
);
  import prfu_pkg::*;

  logic nxt_dec_valid;
  prfu_route_t nxt_dec_route;
  logic [PRFU_NODE_W-1:0] nxt_dec_node;
  logic in_range;
  logic [PRFU_NODE_W-1:0] bit_idx;

  // node 63 is broadcast and nodes below 32 belong to the lower filter
  assign in_range = (pkt_src_node >= PRFU_NODE_FIRST) && (pkt_src_node <= PRFU_NODE_LAST);
  assign bit_idx = pkt_src_node - PRFU_NODE_FIRST; // [R3]

  // next decision
  always_comb begin
    nxt_dec_valid = pkt_valid;
    nxt_dec_node = pkt_src_node;
    nxt_dec_route = PRFU_RT_OTHER;
    if (!pkt_src_local) begin
      // remote source: node bits are not looked at
      if (accept_all_remote_buses) begin // [R6]
        nxt_dec_route = PRFU_RT_PHYS;
      end else begin
        nxt_dec_route = PRFU_RT_DROP; // [R6]
      end
    end else if (in_range) begin // [R5]
      if (!pkt_async_accept) begin
        nxt_dec_route = PRFU_RT_DROP; // [R8]
      end else if (per_node_physical_enable[bit_idx[4:0]]) begin // [R3]
        nxt_dec_route = PRFU_RT_PHYS;
      end else begin
        nxt_dec_route = PRFU_RT_ASYNC; // [R4]
      end
    end
  end

  // decision registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dec_valid_ff <= 1'b0;
      dec_route_ff <= PRFU_RT_OTHER;
      dec_node_ff <= '0;
    end else begin
      dec_valid_ff <= nxt_dec_valid;
      dec_route_ff <= nxt_dec_route;
      dec_node_ff <= nxt_dec_node;
    end
  end

endmodule

// >>> prfu_filter.sv
// upper physical request filter: set/clear register pair, host reset
// handling, routing counters and the per-request decision stage
// assumes a strobe register port on ref_clk and an async host reset pin
`timescale 1ns/1ps

// Operation
// [R1] ones at set/clear addresses set/clear bits
// [R2] all filter bits zero after reset
// [R3] bit n enables physical path for node n+32
// [R4] clear node bit sends request to async context
// [R5] node comparison only for local bus sources
// [R6] remote sources dropped unless bit 31 set
// [R7] host reset leaves bit 31 untouched
// [R8] async filter must accept before physical check
// [R9] reads at set/clear return filter, unchanged
module prfu_filter #(
  parameter int unsigned CNT_W = prfu_pkg::PRFU_CNT_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // host reset pin, active low, asynchronous to ref_clk
  input wire logic host_reset_input_n,
  // register port
  input wire logic [prfu_pkg::PRFU_ADDR_W-1:0] reg_addr,
  input wire logic [prfu_pkg::PRFU_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [prfu_pkg::PRFU_DATA_W-1:0] reg_rdata_ff,
  // request from the receive path
  input wire logic pkt_valid,
  input wire logic [prfu_pkg::PRFU_NODE_W-1:0] pkt_src_node,
  input wire logic pkt_src_local,
  input wire logic pkt_async_accept,
  // decision to the receive path
  output logic dec_valid,
  output prfu_pkg::prfu_route_t dec_route,
  output logic [prfu_pkg::PRFU_NODE_W-1:0] dec_node,
  // filter state for neighbouring logic
  output logic [prfu_pkg::PRFU_NODE_BITS-1:0] per_node_physical_enable_ff,
  output logic accept_all_remote_buses_ff
);
  import prfu_pkg::*;

  // saturating increment, so a long run never wraps to a small count
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = v;
    if (v != {CNT_W{1'b1}}) begin
      r = v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    return r;
  endfunction

  // register hit test shared by write and read decode
  function automatic logic hit(input logic [PRFU_ADDR_W-1:0] a,
                               input logic [PRFU_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // host reset synchroniser
  logic hrst_meta_ff;
  logic hrst_sync_ff;

  // filter state
  logic [PRFU_NODE_BITS-1:0] nxt_node_en;
  logic nxt_all_bus;

  // read data
  logic [PRFU_DATA_W-1:0] nxt_rdata;
  logic [PRFU_DATA_W-1:0] filter_word;

  // counters
  logic [CNT_W-1:0] cnt_phys_ff;
  logic [CNT_W-1:0] cnt_async_ff;
  logic [CNT_W-1:0] cnt_drop_ff;
  logic [CNT_W-1:0] nxt_cnt_phys;
  logic [CNT_W-1:0] nxt_cnt_async;
  logic [CNT_W-1:0] nxt_cnt_drop;

  // write decode
  logic wr_set;
  logic wr_clr;
  logic host_rst_act;

  // decision stage outputs
  logic dec_valid_w;
  prfu_route_t dec_route_w;
  logic [PRFU_NODE_W-1:0] dec_node_w;

  // two flops before anything reads the pin; first flop feeds only the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hrst_meta_ff <= 1'b0;
      hrst_sync_ff <= 1'b0;
    end else begin
      hrst_meta_ff <= host_reset_input_n;
      hrst_sync_ff <= hrst_meta_ff;
    end
  end

  assign host_rst_act = !hrst_sync_ff;

  // strobes are one cycle and exclusive, so set and clear never collide
  assign wr_set = reg_wr && hit(reg_addr, PRFU_OFS_SET);
  assign wr_clr = reg_wr && hit(reg_addr, PRFU_OFS_CLR);

  assign filter_word = {accept_all_remote_buses_ff, per_node_physical_enable_ff};

  // next filter value
  always_comb begin
    nxt_node_en = per_node_physical_enable_ff;
    nxt_all_bus = accept_all_remote_buses_ff;
    if (wr_set) begin
      // zero bits leave their partner unchanged
      nxt_node_en = per_node_physical_enable_ff | reg_wdata[PRFU_NODE_MSB:0]; // [R1]
      nxt_all_bus = accept_all_remote_buses_ff | reg_wdata[PRFU_ALL_BUS_BIT]; // [R1]
    end else if (wr_clr) begin
      nxt_node_en = per_node_physical_enable_ff & ~reg_wdata[PRFU_NODE_MSB:0]; // [R1]
      nxt_all_bus = accept_all_remote_buses_ff & ~reg_wdata[PRFU_ALL_BUS_BIT]; // [R1]
    end
    // host reset clears the node bits only, and beats a write the same cycle
    if (host_rst_act) begin
      nxt_node_en = PRFU_FILTER_RST[PRFU_NODE_MSB:0]; // [R7]
    end
  end

  // filter registers; of the two resets only power-on reset clears the remote-bus flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      per_node_physical_enable_ff <= PRFU_FILTER_RST[PRFU_NODE_MSB:0]; // [R2]
      accept_all_remote_buses_ff <= PRFU_FILTER_RST[PRFU_ALL_BUS_BIT]; // [R2] [R7]
    end else begin
      per_node_physical_enable_ff <= nxt_node_en;
      accept_all_remote_buses_ff <= nxt_all_bus;
    end
  end

  // read mux; data stands in the cycle after the strobe only
  always_comb begin
    nxt_rdata = PRFU_RD_NONE;
    if (reg_rd) begin
      if (hit(reg_addr, PRFU_OFS_SET) || hit(reg_addr, PRFU_OFS_CLR)) begin
        nxt_rdata = filter_word; // [R9]
      end else if (hit(reg_addr, PRFU_OFS_CNT_PHYS)) begin
        nxt_rdata = PRFU_DATA_W'(cnt_phys_ff);
      end else if (hit(reg_addr, PRFU_OFS_CNT_ASYNC)) begin
        nxt_rdata = PRFU_DATA_W'(cnt_async_ff);
      end else if (hit(reg_addr, PRFU_OFS_CNT_DROP)) begin
        nxt_rdata = PRFU_DATA_W'(cnt_drop_ff);
      end
    end
  end

  // read data register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= PRFU_RD_NONE;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // per-request decision, one cycle after the request
  prfu_decide u_decide (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pkt_valid(pkt_valid),
    .pkt_src_node(pkt_src_node),
    .pkt_src_local(pkt_src_local),
    .pkt_async_accept(pkt_async_accept),
    .per_node_physical_enable(per_node_physical_enable_ff),
    .accept_all_remote_buses(accept_all_remote_buses_ff),
    .dec_valid_ff(dec_valid_w),
    .dec_route_ff(dec_route_w),
    .dec_node_ff(dec_node_w)
  );

  // decision outputs come straight from the stage flops
  assign dec_valid = dec_valid_w;
  assign dec_route = dec_route_w;
  assign dec_node = dec_node_w;

  // counter next values; a write of any value to a counter zeroes it,
  // but a decision landing that cycle still counts (count wins)
  always_comb begin
    nxt_cnt_phys = cnt_phys_ff;
    nxt_cnt_async = cnt_async_ff;
    nxt_cnt_drop = cnt_drop_ff;
    if (reg_wr && hit(reg_addr, PRFU_OFS_CNT_PHYS)) begin
      nxt_cnt_phys = '0;
    end
    if (reg_wr && hit(reg_addr, PRFU_OFS_CNT_ASYNC)) begin
      nxt_cnt_async = '0;
    end
    if (reg_wr && hit(reg_addr, PRFU_OFS_CNT_DROP)) begin
      nxt_cnt_drop = '0;
    end
    if (dec_valid_w) begin
      unique case (dec_route_w)
        PRFU_RT_PHYS: begin
          nxt_cnt_phys = sat_inc(nxt_cnt_phys);
        end
        PRFU_RT_ASYNC: begin
          nxt_cnt_async = sat_inc(nxt_cnt_async);
        end
        PRFU_RT_DROP: begin
          nxt_cnt_drop = sat_inc(nxt_cnt_drop);
        end
        PRFU_RT_OTHER: begin
          nxt_cnt_phys = nxt_cnt_phys;
        end
        default: begin
          nxt_cnt_drop = nxt_cnt_drop;
        end
      endcase
    end
  end

  // counter registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_phys_ff <= '0;
      cnt_async_ff <= '0;
      cnt_drop_ff <= '0;
    end else begin
      cnt_phys_ff <= nxt_cnt_phys;
      cnt_async_ff <= nxt_cnt_async;
      cnt_drop_ff <= nxt_cnt_drop;
    end
  end

endmodule

// >>> prfu_filter_asserts.sv
// port checks for the upper physical request filter
// assumes a bind onto prfu_filter, one clock domain
`timescale 1ns/1ps
module prfu_filter_asserts
  import prfu_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic host_reset_input_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  // request and decision
  input wire logic pkt_valid,
  input wire logic [5:0] pkt_src_node,
  input wire logic pkt_src_local,
  input wire logic pkt_async_accept,
  input wire logic dec_valid,
  input wire prfu_route_t dec_route,
  input wire logic [5:0] dec_node,
  // filter state
  input wire logic [30:0] per_node_physical_enable_ff,
  input wire logic accept_all_remote_buses_ff
);
  wire al = accept_all_remote_buses_ff;
  wire [30:0] pe = per_node_physical_enable_ff;
  wire hit = reg_addr == PRFU_OFS_SET || reg_addr == PRFU_OFS_CLR;
  prfu_route_t er;
  // expected route from the filter as it stands at the request edge
  always_comb begin
    if (!pkt_src_local) er = al ? PRFU_RT_PHYS : PRFU_RT_DROP;
    else if (pkt_src_node < 6'h20 || pkt_src_node == 6'h3F) er = PRFU_RT_OTHER;
    else if (!pkt_async_accept) er = PRFU_RT_DROP;
    else er = pe[pkt_src_node - 6'h20] ? PRFU_RT_PHYS : PRFU_RT_ASYNC;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_dec;
    pkt_valid ##1 (dec_valid && dec_node == $past(pkt_src_node));
  endsequence
  sequence s_hr;
    !host_reset_input_n [*3];
  endsequence
  rd_data_a:
    assert property (reg_rd && hit |=> reg_rdata_ff == $past({al, pe})) else $error("read data");
  rd_idle_a:
    assert property (!reg_rd |=> reg_rdata_ff == 32'h00000000) else $error("idle read data");
  set_top_a:
    assert property (reg_wr && reg_addr == PRFU_OFS_SET && reg_wdata[31] |=> al)
      else $error("set bit 31");
  clr_top_a:
    assert property (reg_wr && reg_addr == PRFU_OFS_CLR && reg_wdata[31] |=> !al)
      else $error("clear bit 31");
  keep_top_a:
    assert property (!reg_wr |=> $stable(al)) else $error("bit 31 moved");
  host_clr_a:
    assert property (s_hr |=> pe == 31'h00000000) else $error("host reset clear");
  dec_pulse_a:
    assert property (pkt_valid |-> s_dec) else $error("decision late");
  dec_route_a:
    assert property (pkt_valid |=> dec_route == $past(er)) else $error("route");
endmodule
bind prfu_filter prfu_filter_asserts u_chk (.*);

// >>> prfu_rx_model.sv
// receive path model: one request per go pulse
// assumes go and fields change just after ref_clk rises
`timescale 1ns/1ps
module prfu_rx_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // order from the bench
  input wire logic go,
  input wire logic [7:0] fld,
  // request to the filter
  output logic pkt_valid,
  output logic [5:0] pkt_src_node,
  output logic pkt_src_local,
  output logic pkt_async_accept
);
  logic [7:0] f;
  assign {pkt_src_node, pkt_src_local, pkt_async_accept} = f;
  // idle fields toggle so a stale value never looks valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_valid <= 1'b0;
      f <= 8'h00;
    end else begin
      pkt_valid <= go;
      f <= go ? fld : ~f;
    end
  end
endmodule

// >>> prfu_filter_tb_top.sv
// bench for the upper physical filter: registers, host reset, routing
// assumes the rx model and the bound checker
`timescale 1ns/1ps
module prfu_filter_tb_top;
  import prfu_pkg::*;
  logic ref_clk = 0, resetn = 0, hr_n = 1, wr = 0, rd = 0, go = 0;
  logic [7:0] fld = 0;
  logic [11:0] ad = 0;
  logic [31:0] wd = 0, rdat, mir = 0, r;
  logic pv, pl, pa, dv, al;
  logic [5:0] pn, dn;
  logic [30:0] pe;
  prfu_route_t dr;
  int miscompares = 0, n_compared = 0;
  // expected routing counts for phys, async and drop outcomes
  int cp = 0, ca = 0, cd = 0;
  // 40 MHz register clock
  always #12.5 ref_clk = ~ref_clk;
  prfu_rx_model i_rx (.ref_clk, .resetn, .go, .fld, .pkt_valid(pv), .pkt_src_node(pn),
    .pkt_src_local(pl), .pkt_async_accept(pa));
  prfu_filter i_dut (.ref_clk, .resetn, .host_reset_input_n(hr_n), .reg_addr(ad),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdat), .pkt_valid(pv),
    .pkt_src_node(pn), .pkt_src_local(pl), .pkt_async_accept(pa), .dec_valid(dv),
    .dec_route(dr), .dec_node(dn), .per_node_physical_enable_ff(pe),
    .accept_all_remote_buses_ff(al));
  task automatic chk(logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_dec(logic [9:0] g, e);
    chk({22'h0, g}, {22'h0, e});
  endtask
  task automatic wreg(logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    if (a == PRFU_OFS_SET) mir |= d;
    else if (a == PRFU_OFS_CLR) mir &= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(logic [11:0] a, logic [31:0] e);
    @(posedge ref_clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  function automatic prfu_route_t er(logic [5:0] n, logic l, a);
    if (!l) return mir[31] ? PRFU_RT_PHYS : PRFU_RT_DROP;
    if (n < 6'h20 || n == 6'h3F) return PRFU_RT_OTHER;
    if (!a) return PRFU_RT_DROP;
    return mir[n - 6'h20] ? PRFU_RT_PHYS : PRFU_RT_ASYNC;
  endfunction
  // request goes out through the model, decision two edges later
  task automatic req(logic [5:0] n, logic l, a);
    prfu_route_t e;
    e = er(n, l, a);
    if (e == PRFU_RT_PHYS) cp++;
    else if (e == PRFU_RT_ASYNC) ca++;
    else if (e == PRFU_RT_DROP) cd++;
    @(posedge ref_clk);
    fld <= {n, l, a};
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    #1 chk_dec({dv, dn, dr}, {1'b1, n, e});
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3E2D5FE8));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rreg(PRFU_OFS_SET, 32'h0);
    rreg(PRFU_OFS_CLR, 32'h0);
    req(6'h3E, 1'b1, 1'b1);
    wreg(PRFU_OFS_SET, 32'hFFFFFFFF);
    rreg(PRFU_OFS_CLR, mir);
    req(6'h20, 1'b1, 1'b1);
    req(6'h1F, 1'b1, 1'b1);
    req(6'h3F, 1'b1, 1'b1);
    req(6'h2A, 1'b1, 1'b0);
    wreg(PRFU_OFS_CLR, 32'h40000001);
    rreg(PRFU_OFS_SET, mir);
    req(6'h3E, 1'b1, 1'b1);
    // host reset pin held low, then synchroniser settles
    @(posedge ref_clk);
    hr_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    hr_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    mir &= 32'h80000000;
    rreg(PRFU_OFS_SET, mir);
    req(6'h25, 1'b0, 1'b1);
    wreg(PRFU_OFS_CLR, 32'h80000000);
    req(6'h25, 1'b0, 1'b1);
    wreg(12'h118, 32'hFFFFFFFF);
    rreg(12'h120, 32'h0);
    rreg(PRFU_OFS_SET, mir);
    repeat (80) begin
      r = $urandom();
      case (r[1:0])
        2'h0: wreg(PRFU_OFS_SET, $urandom());
        2'h1: wreg(PRFU_OFS_CLR, $urandom());
        2'h2: rreg(r[2] ? PRFU_OFS_SET : PRFU_OFS_CLR, mir);
        default: req(r[8:3], r[9], r[10]);
      endcase
    end
    // routing counters must agree with the decisions expected above
    rreg(PRFU_OFS_CNT_PHYS, cp);
    rreg(PRFU_OFS_CNT_ASYNC, ca);
    rreg(PRFU_OFS_CNT_DROP, cd);
    wrap_up;
  end
endmodule
